// ===== rtl/dtc_pkg.sv
// Purpose: Shared constants and types for the dual timer control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Offsets 0x88 and 0x89 are register indices; byte address is four times
package dtc_pkg;

    localparam logic [7:0]  DTC_IDX_CONTROL = 8'h88;
    localparam logic [7:0]  DTC_IDX_MODE    = 8'h89;
    localparam logic [11:0] DTC_ADDR_CONTROL = {2'h0, DTC_IDX_CONTROL, 2'h0};
    localparam logic [11:0] DTC_ADDR_MODE    = {2'h0, DTC_IDX_MODE, 2'h0};
    localparam logic [11:0] DTC_ADDR_COUNT0  = 12'h300;
    localparam logic [11:0] DTC_ADDR_COUNT1  = 12'h304;
    localparam logic [11:0] DTC_ADDR_IRQ_STAT = 12'h308;
    localparam logic [11:0] DTC_ADDR_IRQ_MASK = 12'h30c;

    // Control register fields
    localparam int DTC_TF1 = 7;
    localparam int DTC_TR1 = 6;
    localparam int DTC_TF0 = 5;
    localparam int DTC_TR0 = 4;
    localparam int DTC_IE1 = 3;
    localparam int DTC_IT1 = 2;
    localparam int DTC_IE0 = 1;
    localparam int DTC_IT0 = 0;
    // Mode register fields, per timer nibble
    localparam int DTC_GATE_OFS = 3;
    localparam int DTC_CSRC_OFS = 2;
    localparam int DTC_MSEL_HI  = 1;
    localparam int DTC_MSEL_LO  = 0;

    localparam logic [7:0]  DTC_RST_CONTROL = 8'h00;
    localparam logic [7:0]  DTC_RST_MODE    = 8'h00;
    localparam logic [15:0] DTC_RST_COUNT   = 16'h0000;
    localparam logic [3:0]  DTC_RST_IRQ     = 4'h0;
    localparam logic        DTC_RST_PIN     = 1'b1;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_8BIT_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic [15:0] count;
        logic        cin_s1;
        logic        cin_s2;
        logic        cin_prev;
    } dtc_timer_t;

    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  mode;
        dtc_timer_t  tmr0;
        dtc_timer_t  tmr1;
        logic        irq0_s1;
        logic        irq0_s2;
        logic        irq0_prev;
        logic        irq1_s1;
        logic        irq1_s2;
        logic        irq1_prev;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic [31:0] prdata;
        logic        pslverr;
    } dtc_state_t;

endpackage : dtc_pkg

// ===== rtl/dtc_timer_ctrl.sv
// Purpose: Run control, gating, count source, mode and external interrupt flags
// Assumes: Pins are asynchronous and pass two flip-flops; one APB clock
// Notes:   Counters sit in the low 16 bits at their own offsets for visibility
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

//
// Overview of operation
// - Timer 1 overflow sets bit 7; service ack or software clears it.
// - Timer 0 overflow sets bit 5; service ack or software clears it.
// - Bit 6 written by software starts or stops timer 1.
// - Bit 4 written by software starts or stops timer 0.
// - Ext irq 1 flag bit 3: edge sets, ack clears; level tracks inverted pin.
// - Ext irq 0 flag bit 1: edge sets, ack clears; level tracks inverted pin.
// - Bit 2 picks falling edge or low level for ext irq 1.
// - Bit 0 picks falling edge or low level for ext irq 0.
// - Mode bit 7 set: timer 1 counts only while run and irq 1 pin high.
// - Mode bit 3 set: timer 0 counts only while run and irq 0 pin high.
// - Mode bit 6: timer 1 counts clock or counter pin falling edges.
// - Mode bit 2: timer 0 counts clock or counter pin falling edges.
// - Mode bits 5:4 select timer 1 mode, bit 5 upper.
// - Mode bits 1:0 select timer 0 mode, bit 1 upper.
module dtc_timer_ctrl
    import dtc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq0_pin,
    input  wire logic        ext_irq1_pin,
    input  wire logic        counter0_input_pin,
    input  wire logic        counter1_input_pin,
    input  wire logic        timer0_service_ack,
    input  wire logic        timer1_service_ack,
    input  wire logic        ext_irq0_service_ack,
    input  wire logic        ext_irq1_service_ack,
    output logic             irq
);

    dtc_state_t s_q;
    dtc_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Timer step: returns new count and an overflow flag per half
    function automatic logic [17:0] dtc_step(input logic [15:0] cnt,
                                             input logic [1:0]  msel,
                                             input logic        inc_lo,
                                             input logic        inc_hi);
        logic [15:0] n;
        logic        ov_a;
        logic        ov_b;
        n    = cnt;
        ov_a = 1'b0;
        ov_b = 1'b0;
        case (dtc_mode_t'(msel))
            DTC_MODE_13BIT: begin
                if (inc_lo) begin
                    n[4:0] = cnt[4:0] + 5'h01;
                    if (cnt[4:0] == 5'h1f) begin
                        n[15:8] = cnt[15:8] + 8'h01;
                        ov_a    = (cnt[15:8] == 8'hff);
                    end
                end
            end
            DTC_MODE_16BIT: begin
                if (inc_lo) begin
                    n    = cnt + 16'h0001;
                    ov_a = (cnt == 16'hffff);
                end
            end
            DTC_MODE_8BIT_RELOAD: begin
                if (inc_lo) begin
                    n[7:0] = (cnt[7:0] == 8'hff) ? cnt[15:8] : cnt[7:0] + 8'h01;
                    ov_a   = (cnt[7:0] == 8'hff);
                end
            end
            default: begin
                if (inc_lo) begin
                    n[7:0] = cnt[7:0] + 8'h01;
                    ov_a   = (cnt[7:0] == 8'hff);
                end
                if (inc_hi) begin
                    n[15:8] = cnt[15:8] + 8'h01;
                    ov_b    = (cnt[15:8] == 8'hff);
                end
            end
        endcase
        dtc_step = {ov_b, ov_a, n};
    endfunction : dtc_step

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic        wr;
        logic        rd;
        logic        en0;
        logic        en1;
        logic        inc0;
        logic        inc1;
        logic        fall0;
        logic        fall1;
        logic        efall0;
        logic        efall1;
        logic [17:0] r0;
        logic [17:0] r1;
        logic        ov0;
        logic        ov1;
        logic [3:0]  ev;
        logic [7:0]  c;
        logic        hit_ctl;
        logic        hit_mode;
        logic        hit_cnt0;
        logic        hit_cnt1;
        logic        hit_stat;
        logic        hit_mask;
        logic        hit_any;
        wr     = 1'b0;
        rd     = 1'b0;
        en0    = 1'b0;
        en1    = 1'b0;
        inc0   = 1'b0;
        inc1   = 1'b0;
        fall0  = 1'b0;
        fall1  = 1'b0;
        efall0 = 1'b0;
        efall1 = 1'b0;
        r0     = 18'h00000;
        r1     = 18'h00000;
        ov0    = 1'b0;
        ov1    = 1'b0;
        ev     = 4'h0;
        c      = 8'h00;
        hit_ctl  = 1'b0;
        hit_mode = 1'b0;
        hit_cnt0 = 1'b0;
        hit_cnt1 = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_any  = 1'b0;
        s_d    = s_q;

        // Pin synchronisers, then one stage of history for edge detection
        s_d.irq0_s1       = ext_irq0_pin;
        s_d.irq0_s2       = s_q.irq0_s1;
        s_d.irq0_prev     = s_q.irq0_s2;
        s_d.irq1_s1       = ext_irq1_pin;
        s_d.irq1_s2       = s_q.irq1_s1;
        s_d.irq1_prev     = s_q.irq1_s2;
        s_d.tmr0.cin_s1   = counter0_input_pin;
        s_d.tmr0.cin_s2   = s_q.tmr0.cin_s1;
        s_d.tmr0.cin_prev = s_q.tmr0.cin_s2;
        s_d.tmr1.cin_s1   = counter1_input_pin;
        s_d.tmr1.cin_s2   = s_q.tmr1.cin_s1;
        s_d.tmr1.cin_prev = s_q.tmr1.cin_s2;

        // Falling edges seen on the synchronised pins
        fall0  = s_q.tmr0.cin_prev & ~s_q.tmr0.cin_s2;
        fall1  = s_q.tmr1.cin_prev & ~s_q.tmr1.cin_s2;
        efall0 = s_q.irq0_prev & ~s_q.irq0_s2;
        efall1 = s_q.irq1_prev & ~s_q.irq1_s2;

        // Count enables and count sources
        en0 = s_q.control[DTC_TR0]
            & (~s_q.mode[DTC_GATE_OFS] | s_q.irq0_s2);
        en1 = s_q.control[DTC_TR1]
            & (~s_q.mode[4 + DTC_GATE_OFS] | s_q.irq1_s2);
        inc0 = s_q.mode[DTC_CSRC_OFS] ? fall0 : 1'b1;
        inc1 = s_q.mode[4 + DTC_CSRC_OFS] ? fall1 : 1'b1;

        // In split mode timer 0's high half runs on timer 1's run bit
        r0 = dtc_step(s_q.tmr0.count, s_q.mode[1:0], en0 & inc0,
                      s_q.control[DTC_TR1]);
        if (s_q.mode[1:0] == 2'b11) begin
            r1 = dtc_step(s_q.tmr1.count, 2'b01, 1'b0, 1'b0);
        end else begin
            r1 = dtc_step(s_q.tmr1.count, s_q.mode[5:4], en1 & inc1,
                          1'b0);
        end
        s_d.tmr0.count = r0[15:0];
        s_d.tmr1.count = r1[15:0];
        ov0 = r0[16];
        ov1 = r1[16] | r0[17];

        // Bus strobes and address hits
        wr = psel & penable & pwrite;
        rd = psel & ~penable & ~pwrite;
        hit_ctl  = (paddr == DTC_ADDR_CONTROL);
        hit_mode = (paddr == DTC_ADDR_MODE);
        hit_cnt0 = (paddr == DTC_ADDR_COUNT0);
        hit_cnt1 = (paddr == DTC_ADDR_COUNT1);
        hit_stat = (paddr == DTC_ADDR_IRQ_STAT);
        hit_mask = (paddr == DTC_ADDR_IRQ_MASK);
        hit_any  = hit_ctl | hit_mode | hit_cnt0 | hit_cnt1 | hit_stat | hit_mask;

        c = s_q.control;
        // Control flags: hardware set beats service ack, both beat the write
        if (wr && hit_ctl) begin
            c = pwdata[7:0];
        end
        if (timer0_service_ack) begin
            c[DTC_TF0] = 1'b0;
        end
        if (timer1_service_ack) begin
            c[DTC_TF1] = 1'b0;
        end
        if (ov0) begin
            c[DTC_TF0] = 1'b1;
        end
        if (ov1) begin
            c[DTC_TF1] = 1'b1;
        end
        if (s_q.control[DTC_IT0]) begin
            if (ext_irq0_service_ack) begin
                c[DTC_IE0] = 1'b0;
            end
            if (efall0) begin
                c[DTC_IE0] = 1'b1;
            end
        end else begin
            c[DTC_IE0] = ~s_q.irq0_s2;
        end
        if (s_q.control[DTC_IT1]) begin
            if (ext_irq1_service_ack) begin
                c[DTC_IE1] = 1'b0;
            end
            if (efall1) begin
                c[DTC_IE1] = 1'b1;
            end
        end else begin
            c[DTC_IE1] = ~s_q.irq1_s2;
        end
        s_d.control = c;

        // Plain software registers; a count write overrides that cycle's step
        if (wr && hit_mode) begin
            s_d.mode = pwdata[7:0];
        end
        if (wr && hit_cnt0) begin
            s_d.tmr0.count = pwdata[15:0];
        end
        if (wr && hit_cnt1) begin
            s_d.tmr1.count = pwdata[15:0];
        end
        if (wr && hit_mask) begin
            s_d.irq_mask = pwdata[3:0];
        end

        // Sticky events: set wins over write-one-to-clear
        ev[0] = ov0;
        ev[1] = ov1;
        ev[2] = efall0;
        ev[3] = efall1;
        if (wr && hit_stat) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[3:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;

        if (rd) begin
            s_d.pslverr = 1'b0;
            if (hit_ctl) begin
                s_d.prdata = {24'h000000, s_q.control};
            end else if (hit_mode) begin
                s_d.prdata = {24'h000000, s_q.mode};
            end else if (hit_cnt0) begin
                s_d.prdata = {16'h0000, s_q.tmr0.count};
            end else if (hit_cnt1) begin
                s_d.prdata = {16'h0000, s_q.tmr1.count};
            end else if (hit_stat) begin
                s_d.prdata = {28'h0000000, s_q.irq_stat};
            end else if (hit_mask) begin
                s_d.prdata = {28'h0000000, s_q.irq_mask};
            end else begin
                s_d.prdata  = 32'h00000000;
                s_d.pslverr = 1'b1;
            end
        end else if (psel && !penable) begin
            s_d.prdata  = 32'h00000000;
            s_d.pslverr = ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.control <= DTC_RST_CONTROL;
            s_q.mode <= DTC_RST_MODE;
            s_q.tmr0.count <= DTC_RST_COUNT;
            s_q.tmr1.count <= DTC_RST_COUNT;
            s_q.irq_stat <= DTC_RST_IRQ;
            s_q.irq_mask <= DTC_RST_IRQ;
            // Synchronisers start at the idle pin level: no false edge or level flag
            s_q.irq0_s1 <= DTC_RST_PIN;
            s_q.irq0_s2 <= DTC_RST_PIN;
            s_q.irq0_prev <= DTC_RST_PIN;
            s_q.irq1_s1 <= DTC_RST_PIN;
            s_q.irq1_s2 <= DTC_RST_PIN;
            s_q.irq1_prev <= DTC_RST_PIN;
            s_q.tmr0.cin_s1 <= DTC_RST_PIN;
            s_q.tmr0.cin_s2 <= DTC_RST_PIN;
            s_q.tmr0.cin_prev <= DTC_RST_PIN;
            s_q.tmr1.cin_s1 <= DTC_RST_PIN;
            s_q.tmr1.cin_s2 <= DTC_RST_PIN;
            s_q.tmr1.cin_prev <= DTC_RST_PIN;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr & psel & penable;
    assign pready  = 1'b1;
    assign irq     = |(s_q.irq_stat & s_q.irq_mask);

endmodule : dtc_timer_ctrl

// ===== bench/dtc_sva.sv
// Purpose: Port checks for the dual timer control block
// Assumes: Zero-wait APB; pin levels reach flags within three cycles
// Notes:   Shadows track software writes only
`timescale 1ns/1ps
module dtc_sva
    import dtc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_irq0_pin,
    input wire logic        ext_irq1_pin,
    input wire logic        irq
);
    logic [7:0] mode_q, ctl_q;
    logic [3:0] msk_q, msk_old_q;
    logic [4:0] h0_q, h1_q;
    logic [1:0] age_q;
    wire rd = psel && penable && !pwrite;
    wire wr = psel && penable && pwrite;
    wire map = paddr inside {DTC_ADDR_CONTROL, DTC_ADDR_MODE, DTC_ADDR_COUNT0,
        DTC_ADDR_COUNT1, DTC_ADDR_IRQ_STAT, DTC_ADDR_IRQ_MASK};
    // Mixed reset history so a low pin level needs five real samples, a high one four, to count as steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 8'h00;
            ctl_q <= 8'h00;
            msk_q <= 4'h0;
            msk_old_q <= 4'h0;
            h0_q <= 5'h15;
            h1_q <= 5'h15;
            age_q <= 2'h0;
        end else begin
            if (wr && paddr == DTC_ADDR_MODE) mode_q <= pwdata[7:0];
            if (wr && paddr == DTC_ADDR_CONTROL) ctl_q <= pwdata[7:0];
            if (wr && paddr == DTC_ADDR_IRQ_MASK) msk_q <= pwdata[3:0];
            msk_old_q <= msk_q;
            h0_q <= {h0_q[3:0], ext_irq0_pin};
            h1_q <= {h1_q[3:0], ext_irq1_pin};
            if (wr && paddr == DTC_ADDR_CONTROL) age_q <= 2'h0;
            else if (age_q != 2'h3) age_q <= age_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr idle");
    unmapped_err_a: assert property (psel && penable && !map |-> pslverr
        && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
    mapped_ok_a: assert property (psel && penable && map |-> !pslverr)
        else $error("mapped access refused");
    mode_back_a: assert property (rd && paddr == DTC_ADDR_MODE
        |-> prdata == {24'h0, mode_q}) else $error("mode readback wrong");
    ctl_back_a: assert property (rd && paddr == DTC_ADDR_CONTROL
        |-> prdata[31:8] == 24'h0 && prdata[6] == ctl_q[6] && prdata[4] == ctl_q[4]
        && prdata[2] == ctl_q[2] && prdata[0] == ctl_q[0]) else $error("control readback wrong");
    level0_a: assert property (rd && paddr == DTC_ADDR_CONTROL && age_q == 2'h3
        && !ctl_q[0] && h0_q == {5{ext_irq0_pin}} |-> prdata[1] == !ext_irq0_pin)
        else $error("level flag 0 not tracking pin");
    level1_a: assert property (rd && paddr == DTC_ADDR_CONTROL && age_q == 2'h3
        && !ctl_q[2] && h1_q == {5{ext_irq1_pin}} |-> prdata[3] == !ext_irq1_pin)
        else $error("level flag 1 not tracking pin");
    masked_a: assert property (msk_q == 4'h0 && msk_old_q == 4'h0 |-> !irq)
        else $error("irq while fully masked");
    cover property (rd && paddr == DTC_ADDR_CONTROL && prdata[5]);
    cover property (irq);
    cover property (psel && penable && !map);
endmodule : dtc_sva

bind dtc_timer_ctrl dtc_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin), .irq(irq));

// ===== bench/dtc_pins.sv
// Purpose: External interrupt and counter pins seen by the block
// Assumes: Pins idle high through pull-ups
// Notes:   Changes land just after a rising edge
`timescale 1ns/1ps
module dtc_pins (
    input  wire logic pclk,
    output logic      ext_irq0_pin,
    output logic      ext_irq1_pin,
    output logic      counter0_input_pin,
    output logic      counter1_input_pin
);
    initial begin
        ext_irq0_pin = 1'b1;
        ext_irq1_pin = 1'b1;
        counter0_input_pin = 1'b1;
        counter1_input_pin = 1'b1;
    end
    task automatic set_irq(input int i, input logic v);
        @(posedge pclk);
        if (i == 0) ext_irq0_pin <= v;
        else ext_irq1_pin <= v;
    endtask : set_irq
    // Each low phase spans three clocks and each high phase four, so the synchroniser sees it
    task automatic pulse_cnt(input int i, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (i == 0) counter0_input_pin <= 1'b0;
            else counter1_input_pin <= 1'b0;
            repeat (3) @(posedge pclk);
            if (i == 0) counter0_input_pin <= 1'b1;
            else counter1_input_pin <= 1'b1;
            repeat (3) @(posedge pclk);
        end
    endtask : pulse_cnt
endmodule : dtc_pins

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the dual timer control block
// Assumes: Zero-wait APB slave
// Notes:   Run, count, overflow and external interrupt scenarios run for both timers
`timescale 1ns/1ps
module tb_top;
    import dtc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  ack = 4'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, irq, se, p0, p1, c0, c1;
    int          errors = 0;
    int          n_tests = 0;
    always #5 pclk = ~pclk;
    dtc_timer_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq0_pin(p0), .ext_irq1_pin(p1), .counter0_input_pin(c0),
        .counter1_input_pin(c1), .timer0_service_ack(ack[0]), .timer1_service_ack(ack[1]),
        .ext_irq0_service_ack(ack[2]), .ext_irq1_service_ack(ack[3]), .irq(irq));
    dtc_pins pins (.pclk(pclk), .ext_irq0_pin(p0), .ext_irq1_pin(p1),
        .counter0_input_pin(c0), .counter1_input_pin(c1));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input int k);
        @(posedge pclk);
        ack[k] <= 1'b1;
        @(posedge pclk);
        ack[k] <= 1'b0;
    endtask : pulse
    // Reads are three clocks apart, so a free-running count advances by three
    task automatic diff2(input logic [11:0] a, input logic [31:0] d, input string nm);
        logic [31:0] f;
        apb(1'b0, a, 32'h0);
        f = r;
        apb(1'b0, a, 32'h0);
        chk(nm, f + d, r);
    endtask : diff2
    task automatic t_reset;
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("control", 32'h0, r);
        apb(1'b1, DTC_ADDR_MODE, 32'hffff_ffa5);
        apb(1'b0, DTC_ADDR_MODE, 32'h0);
        chk("mode", 32'h0000_00a5, r);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h0, r);
        chk("slverr", 32'h1, {31'h0, se});
        apb(1'b1, DTC_ADDR_MODE, 32'h0);
    endtask : t_reset
    task automatic t_run(input int i);
        logic [11:0] ca;
        ca = i ? DTC_ADDR_COUNT1 : DTC_ADDR_COUNT0;
        apb(1'b1, DTC_ADDR_MODE, i ? 32'h10 : 32'h01);
        pins.set_irq(i, 1'b0);
        apb(1'b1, DTC_ADDR_CONTROL, i ? 32'h40 : 32'h10);
        diff2(ca, 32'd3, "ungated");
        apb(1'b1, DTC_ADDR_MODE, i ? 32'h90 : 32'h09);
        diff2(ca, 32'd0, "gated");
        pins.set_irq(i, 1'b1);
        repeat (4) @(posedge pclk);
        diff2(ca, 32'd3, "gate open");
        apb(1'b1, DTC_ADDR_CONTROL, 32'h0);
        diff2(ca, 32'd0, "stopped");
    endtask : t_run
    task automatic t_cnt(input int i);
        logic [11:0] ca;
        logic [31:0] f;
        ca = i ? DTC_ADDR_COUNT1 : DTC_ADDR_COUNT0;
        apb(1'b1, DTC_ADDR_MODE, i ? 32'h50 : 32'h05);
        apb(1'b1, DTC_ADDR_CONTROL, i ? 32'h40 : 32'h10);
        apb(1'b0, ca, 32'h0);
        f = r;
        pins.pulse_cnt(i, 5);
        repeat (5) @(posedge pclk);
        apb(1'b0, ca, 32'h0);
        chk("edge count", f + 32'd5, r);
        apb(1'b1, DTC_ADDR_CONTROL, 32'h0);
    endtask : t_cnt
    task automatic t_ovf(input int i);
        int fb;
        fb = i ? 7 : 5;
        apb(1'b1, DTC_ADDR_MODE, i ? 32'h20 : 32'h02);
        apb(1'b1, DTC_ADDR_CONTROL, i ? 32'h40 : 32'h10);
        repeat (300) @(posedge pclk);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("overflow", 32'h1, {31'h0, r[fb]});
        // Stop the timer but keep its flag, so no later overflow races the checks
        apb(1'b1, DTC_ADDR_CONTROL, 32'h1 << fb);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, DTC_ADDR_IRQ_MASK, 32'h1 << i);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        pulse(i);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("ack clear", 32'h0, {31'h0, r[fb]});
        apb(1'b1, DTC_ADDR_IRQ_STAT, 32'h1 << i);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, DTC_ADDR_CONTROL, 32'h1 << fb);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("soft set", 32'h1, {31'h0, r[fb]});
        apb(1'b1, DTC_ADDR_CONTROL, 32'h0);
        apb(1'b1, DTC_ADDR_IRQ_MASK, 32'h0);
    endtask : t_ovf
    task automatic t_ext(input int i);
        int fb;
        fb = i ? 3 : 1;
        apb(1'b1, DTC_ADDR_IRQ_STAT, 32'hf);
        apb(1'b0, DTC_ADDR_IRQ_STAT, 32'h0);
        chk("status clear", 32'h0, {31'h0, r[i + 2]});
        apb(1'b1, DTC_ADDR_CONTROL, i ? 32'h04 : 32'h01);
        pins.set_irq(i, 1'b0);
        repeat (5) @(posedge pclk);
        pins.set_irq(i, 1'b1);
        repeat (5) @(posedge pclk);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("edge flag", 32'h1, {31'h0, r[fb]});
        apb(1'b0, DTC_ADDR_IRQ_STAT, 32'h0);
        chk("edge status", 32'h1, {31'h0, r[i + 2]});
        pulse(i + 2);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("vector clear", 32'h0, {31'h0, r[fb]});
        apb(1'b1, DTC_ADDR_CONTROL, 32'h0);
        pins.set_irq(i, 1'b0);
        repeat (5) @(posedge pclk);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("level low", 32'h1, {31'h0, r[fb]});
        pins.set_irq(i, 1'b1);
        repeat (5) @(posedge pclk);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("level high", 32'h0, {31'h0, r[fb]});
        apb(1'b1, DTC_ADDR_IRQ_STAT, 32'hf);
    endtask : t_ext
    // Timer 0 in 13-bit and split modes
    task automatic t_mode;
        apb(1'b1, DTC_ADDR_MODE, 32'h00);
        apb(1'b1, DTC_ADDR_CONTROL, 32'h10);
        apb(1'b1, DTC_ADDR_COUNT0, 32'h05ff);
        apb(1'b0, DTC_ADDR_COUNT0, 32'h0);
        chk("13-bit carry", 32'h0000_06e0, r);
        apb(1'b1, DTC_ADDR_MODE, 32'h03);
        apb(1'b1, DTC_ADDR_CONTROL, 32'h40);
        apb(1'b1, DTC_ADDR_COUNT0, 32'hfe00);
        apb(1'b0, DTC_ADDR_COUNT0, 32'h0);
        chk("split high", 32'h0000_ff00, r);
        apb(1'b0, DTC_ADDR_CONTROL, 32'h0);
        chk("split flags", 32'h0000_00c0, r);
        diff2(DTC_ADDR_COUNT1, 32'd0, "split halt");
        apb(1'b1, DTC_ADDR_CONTROL, 32'h0);
        apb(1'b1, DTC_ADDR_MODE, 32'h0);
    endtask : t_mode
    task automatic wrap_up;
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        for (int i = 0; i < 2; i++) begin
            t_run(i);
            t_cnt(i);
            t_ovf(i);
            t_ext(i);
        end
        t_mode;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        wrap_up;
    end
endmodule : tb_top
